// ---- testbench/mod_model.sv ----
// Purpose: Modulator stand-in that feeds the filter's bitstream pin
// Assumes: One bit per modulator tick, a tick every MOD_CYC clocks
// Notes: First-order loop on a fixed level, so the stream keeps moving
`timescale 1ns/100ps
`default_nettype none
module mod_model (
   input wire logic clk,
   input wire logic rst_n,
   output var logic modBit
);
   // --------------------------------------------------------------
   // Tick counter and loop state
   // --------------------------------------------------------------
   logic [7:0] tickCnt_ff;
   logic [2:0] acc_ff;
   logic [3:0] nxt_acc;
   // Carry out of the loop sum is the bit, a density of three eighths
   assign nxt_acc = {1'b0, acc_ff} + 4'h3;
   // Bit changes once per tick only; held between ticks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_ff <= 8'h00;
         acc_ff <= 3'h0;
         modBit <= 1'b0;
      end else if (tickCnt_ff == 8'(sdf_pkg::MOD_CYC - 1)) begin
         tickCnt_ff <= 8'h00;
         acc_ff <= nxt_acc[2:0];
         modBit <= nxt_acc[3];
      end else begin
         tickCnt_ff <= tickCnt_ff + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench of the decimation filter
// Assumes: Zero-wait APB, modulator tick every 100 clocks
// Notes: Output pacing is judged by cycles between data-ready pulses
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // --------------------------------------------------------------
   // Signals and counters
   // --------------------------------------------------------------
   localparam int DEC_CYC = sdf_pkg::MOD_CYC * sdf_pkg::SINC5_DEC;
   logic clk, rst_n, psel, penable, pwrite, modBit;
   logic chanSwitch, multiChan, pready, pslverr, resultValid, rdyN, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, result, rdq;
   logic [3:0] pstrb, chanIndex, resultChan;
   logic [2:0] setupSel;
   logic rde;
   int errors = 0;
   int compares = 0;
   int n;
   sigma_delta_decimation_filter u_sigma_delta_decimation_filter (
      .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .modBit(modBit), .setupSel(setupSel), .chanIndex(chanIndex),
      .chanSwitch(chanSwitch), .multiChan(multiChan), .result(result),
      .resultChan(resultChan), .resultValid(resultValid), .rdyN(rdyN),
      .irq(irq));
   mod_model u_mod_model (.clk(clk), .rst_n(rst_n), .modBit(modBit));
   // --------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------
   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for pready, bounded
   task automatic apb(input logic [7:0] a, input logic w,
         input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rdq = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 16) begin
         errors++;
         test_done();
      end
   endtask
   // Counts cycles up to the next data-ready pulse, bounded; looks
   // mid-cycle where rdyN is settled, returns on a rising edge
   task automatic wait_rdy(output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (rdyN !== 1'b0 && c < 30000);
      @(posedge clk);
      if (c >= 30000) begin
         errors++;
         test_done();
      end
   endtask
   // Sequencer step: new channel and setup with a flush pulse
   task automatic switch_to(input logic [2:0] s, input logic [3:0] ch);
      @(posedge clk);
      chanSwitch <= 1'b1;
      setupSel <= s;
      chanIndex <= ch;
      @(posedge clk);
      chanSwitch <= 1'b0;
   endtask
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic test_regs();
      apb(sdf_pkg::STAT_OFS, 1'b0, 32'h0);
      chk(rdq, 32'h0000_0004); // Flush after reset
      apb(sdf_pkg::STAT_OFS, 1'b0, 32'h0);
      chk(rdq, 32'h0000_0000); // Cleared by the read
      apb(sdf_pkg::FILT_OFS + 8'h04, 1'b0, 32'h0);
      chk(rdq, 32'(sdf_pkg::FILT_RST));
      apb(sdf_pkg::MODE_OFS, 1'b0, 32'h0);
      chk(rdq, sdf_pkg::MODE_RST);
      apb(8'h34, 1'b0, 32'h0);
      chk({rdq[30:0], rde}, 32'h0000_0001);
      $display("register test done");
   endtask
   task automatic test_sinc5();
      apb(sdf_pkg::FILT_OFS, 1'b1, 32'h0000_0001);
      switch_to(3'h0, 4'h5);
      wait_rdy(n);
      chk({31'h0, n >= 5 * DEC_CYC}, 32'h1);
      chk(32'(resultChan), 32'h5);
      chk(32'(irq), 32'h0);
      wait_rdy(n);
      chk(32'(n), 32'(2 * DEC_CYC));
      // Stream mean -1/4: two settled sinc5 words of -2^23, top 32 bits
      chk(result, 32'hFFFF_C000);
      $display("sinc5 test done");
   endtask
   task automatic test_sinc3();
      apb(sdf_pkg::FILT_OFS + 8'h04, 1'b1, 32'h0000_8001);
      switch_to(3'h1, 4'h2);
      wait_rdy(n);
      wait_rdy(n);
      chk(32'(n), 32'(DEC_CYC));
      chk(32'(resultChan), 32'h2);
      apb(sdf_pkg::MODE_OFS, 1'b1, 32'h0000_0001);
      wait_rdy(n);
      wait_rdy(n);
      wait_rdy(n);
      chk(32'(n), 32'(3 * DEC_CYC));
      multiChan <= 1'b1;
      wait_rdy(n);
      wait_rdy(n);
      wait_rdy(n);
      chk(32'(n), 32'(DEC_CYC));
      multiChan <= 1'b0;
      apb(sdf_pkg::MODE_OFS, 1'b1, 32'h0000_0000);
      $display("sinc3 test done");
   endtask
   task automatic test_irq();
      apb(sdf_pkg::MASK_OFS, 1'b1, 32'h0000_0001);
      wait_rdy(n);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      apb(sdf_pkg::STAT_OFS, 1'b0, 32'h0);
      chk(rdq & 32'h1, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      $display("interrupt test done");
   endtask
   // --------------------------------------------------------------
   // Clock, reset and sequence
   // --------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      setupSel = 3'h0;
      chanIndex = 4'h0;
      chanSwitch = 1'b0;
      multiChan = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      test_regs();
      test_sinc5();
      test_sinc3();
      test_irq();
      test_done();
   end
endmodule
`default_nettype wire

// ---- verilog/cic_if.sv ----
// Purpose: Carrier between the filter control and one sinc stage
// Assumes: One clock domain
// Notes: The stage drives only the output word
`timescale 1ns/100ps
`default_nettype none
interface cic_if #(parameter int W = 64);
   logic inValid;
   logic smp;
   logic decim;
   logic flush;
   logic [W-1:0] out;
   modport feed (output inValid, output smp, output decim, output flush,
      input out);
   modport stage (input inValid, input smp, input decim, input flush,
      output out);
endinterface
`default_nettype wire

// ---- verilog/cic_stage.sv ----
// Purpose: Sinc filter of given order as integrators and combs
// Assumes: Bitstream sample as +1 or -1, decimation strobe from outside
// Notes: Arithmetic wraps modulo 2^W, which cancels in the combs
`timescale 1ns/100ps
`default_nettype none
module cic_stage #(
   parameter int ORDER = 3,
   parameter int W = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   cic_if.stage cic
);
   logic [W-1:0] integ_ff [ORDER];
   logic [W-1:0] dly_ff [ORDER];
   logic [W-1:0] comb [ORDER+1];
   logic [W-1:0] out_ff;
   wire logic [W-1:0] step = cic.smp ? W'(1) : '1;

   // Comb chain, differenced against the previous decimated values
   always_comb begin
      comb[0] = integ_ff[ORDER-1];
      for (int i = 0; i < ORDER; i++) begin
         comb[i+1] = comb[i] - dly_ff[i];
      end
   end

   // Flush clears all history so the next result restarts settling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < ORDER; i++) begin
            integ_ff[i] <= '0;
            dly_ff[i] <= '0;
         end
         out_ff <= '0;
      end else if (cic.flush) begin
         for (int i = 0; i < ORDER; i++) begin
            integ_ff[i] <= '0;
            dly_ff[i] <= '0;
         end
         out_ff <= '0;
      end else begin
         if (cic.inValid) begin
            integ_ff[0] <= integ_ff[0] + step;
            for (int i = 1; i < ORDER; i++) begin
               integ_ff[i] <= integ_ff[i] + integ_ff[i-1];
            end
         end
         if (cic.decim) begin
            for (int i = 0; i < ORDER; i++) begin
               dly_ff[i] <= comb[i];
            end
            out_ff <= comb[ORDER];
         end
      end
   end

   assign cic.out = out_ff;
endmodule
`default_nettype wire

// ---- verilog/sdf_pkg.sv ----
// Purpose: Shared constants and types of the sigma-delta decimation filter
// Assumes: 100 MHz system clock, 2 MHz nominal master clock
// Notes: Register offsets are byte addresses on a 32-bit APB bus
package sdf_pkg;
   // ----------------------------------------------------------------
   // Clocking and filter rates
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int MCLK_HZ = 2_000_000;
   localparam int MOD_HZ = MCLK_HZ / 2;
   localparam int MOD_CYC = CLK_HZ / MOD_HZ;
   localparam int SINC5_DEC = 32;
   localparam int SINC5_SPS = MOD_HZ / SINC5_DEC;
   localparam int SINGLE_SETTLE_SPS = 2600;
   localparam int SC_FAST_SPS = 10_000;
   localparam int SINC5_PRIME = 5;
   localparam int SINC3_SETTLE_OUT = 3;
   localparam int SINC3_DMAP_MUL = 32;
   // Enhanced post-filter settings, rate in mSPS and settling in us
   localparam int ENH_SPS_X1000 [4] = '{27270, 25000, 20000, 16667};
   localparam int ENH_SETTLE_US [4] = '{36670, 40000, 50000, 60000};
   // ----------------------------------------------------------------
   // Data path widths
   // ----------------------------------------------------------------
   localparam int W5 = 26;
   localparam int W3 = 64;
   localparam int W1 = 42;
   localparam int FILT_W = 16;
   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] FILT_OFS = 8'h00;
   localparam logic [7:0] MODE_OFS = 8'h20;
   localparam logic [7:0] STAT_OFS = 8'h24;
   localparam logic [7:0] MASK_OFS = 8'h28;
   localparam logic [7:0] DATA_OFS = 8'h2C;
   localparam logic [7:0] INFO_OFS = 8'h30;
   localparam int DMAP_BIT = 15;
   localparam int ENH_EN_BIT = 11;
   localparam int ENH_SEL_LSB = 8;
   localparam int ORDER_LSB = 5;
   localparam int ODR_LSB = 0;
   localparam int SC_BIT = 0;
   localparam int SCALE_LSB = 4;
   localparam int EV_READY = 0;
   localparam int EV_OVERRUN = 1;
   localparam int EV_FLUSH = 2;
   localparam logic [1:0] ORD_SINC5 = 2'b00;
   localparam logic [1:0] ORD_SINC3 = 2'b11;
   localparam logic [15:0] FILT_RST = 16'h0000;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [2:0] MASK_RST = 3'h0;
   // ----------------------------------------------------------------
   // Conversion control states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_FLUSH = 2'b00,
      ST_PRIME = 2'b01,
      ST_RUN = 2'b10
   } conv_state_t;
endpackage

// ---- verilog/sigma_delta_decimation_filter.sv ----
// Purpose: Decimation filter for a multichannel sigma-delta converter
// Assumes: Modulator bit arrives on a pin, sequencer logic on clk
// Notes: Results are raw and unscaled; calibration lies outside
// Operation
// R1 - Three paths: sinc5+sinc1, sinc3, enhanced
// R2 - Filter and rate come from selected setup
// R3 - Sinc5+sinc1 settles in one cycle at low rates
// R4 - Sinc5 fixed 31.25k, sinc1 ratio sets rate
// R5 - Sinc3 settles in three output periods
// R6 - Direct map bit makes register sinc3 decimation
// R7 - Direct rate is modulator rate over 32*value
// R8 - Single-cycle bit emits only settled results
// R9 - Single-cycle ignored below 10k or multichannel
// R10 - Without it sinc3 emits every nominal output
// R11 - Data-ready pulses at the settled rate
// R12 - Enhanced filters post-process sinc5+sinc1 output
// R13 - Enhanced 27.27 and 25 SPS settings
// R14 - Enhanced 20 and 16.667 SPS settings
// R15 - Enhanced filters reject 50 and 60 Hz
// R16 - Slower master clock scales every rate
// R17 - Channel switch flushes filter state
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sigma_delta_decimation_filter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic modBit,
   input wire logic [2:0] setupSel,
   input wire logic [3:0] chanIndex,
   input wire logic chanSwitch,
   input wire logic multiChan,
   output logic [31:0] result,
   output logic [3:0] resultChan,
   output logic resultValid,
   output logic rdyN,
   output logic irq
);
   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [15:0] filt_ff [8];
   logic [31:0] mode_ff, prdata_ff, result_ff;
   logic [2:0] status_ff, mask_ff;
   logic [3:0] chan_ff;
   logic valid_ff, sync1_ff, sync2_ff;
   logic [19:0] div_ff;
   logic [4:0] cnt5_ff;
   logic [20:0] cnt3_ff;
   logic [15:0] n1_ff;
   logic [2:0] prime_ff;
   logic [sdf_pkg::W1-1:0] acc_ff;
   logic d5_ff, d3_ff;
   sdf_pkg::conv_state_t state_ff, nxt_state;
   cic_if #(.W(sdf_pkg::W5)) c5 ();
   cic_if #(.W(sdf_pkg::W3)) c3 ();

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire logic setupPh = psel && !penable;
   wire logic accessPh = psel && penable;
   wire logic filtHit = paddr[7:5] == 3'b000;
   wire logic mapped = (paddr[1:0] == 2'b00) &&
      (filtHit || paddr == sdf_pkg::MODE_OFS ||
       paddr == sdf_pkg::STAT_OFS || paddr == sdf_pkg::MASK_OFS ||
       paddr == sdf_pkg::DATA_OFS || paddr == sdf_pkg::INFO_OFS);
   wire logic wrEn = accessPh && pwrite && mapped;
   wire logic stRead = accessPh && !pwrite && paddr == sdf_pkg::STAT_OFS;
   wire logic [31:0] strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
      {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire logic [31:0] filtRd = {16'h0000, filt_ff[paddr[4:2]]};
   wire logic [31:0] infoRd = {24'h000000, 2'b00, state_ff, chan_ff};
   wire logic [31:0] rdMux =
      filtHit ? filtRd :
      paddr == sdf_pkg::MODE_OFS ? mode_ff :
      paddr == sdf_pkg::STAT_OFS ? {29'h0, status_ff} :
      paddr == sdf_pkg::MASK_OFS ? {29'h0, mask_ff} :
      paddr == sdf_pkg::DATA_OFS ? result_ff :
      paddr == sdf_pkg::INFO_OFS ? infoRd : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = accessPh && !mapped;
   assign prdata = prdata_ff;

   // Read data latched in the setup phase so the access needs no wait
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setupPh) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rdMux;
      end
   end

   // Configuration writes honour byte strobes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            filt_ff[i] <= sdf_pkg::FILT_RST;
         end
         mode_ff <= sdf_pkg::MODE_RST;
         mask_ff <= sdf_pkg::MASK_RST;
      end else if (wrEn) begin
         if (filtHit) begin
            filt_ff[paddr[4:2]] <= (filt_ff[paddr[4:2]] & ~strbMask[15:0])
               | (pwdata[15:0] & strbMask[15:0]);
         end
         if (paddr == sdf_pkg::MODE_OFS) begin
            mode_ff <= (mode_ff & ~strbMask) | (pwdata & strbMask);
         end
         if (paddr == sdf_pkg::MASK_OFS && pstrb[0]) begin
            mask_ff <= pwdata[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Setup decode
   // ----------------------------------------------------------------
   wire logic [15:0] cfg = filt_ff[setupSel]; // [R2]
   wire logic dmap = cfg[sdf_pkg::DMAP_BIT]; // [R6]
   wire logic isSinc3 = dmap ||
      cfg[sdf_pkg::ORDER_LSB +: 2] == sdf_pkg::ORD_SINC3; // [R1]
   // Enhanced only exists behind sinc5+sinc1; ignored under sinc3
   wire logic enh = !isSinc3 && cfg[sdf_pkg::ENH_EN_BIT]; // [R12]
   wire logic [1:0] enhSel = cfg[sdf_pkg::ENH_SEL_LSB +: 2];
   wire logic [15:0] ratio = 16'(1) << cfg[sdf_pkg::ODR_LSB +: 4];
   wire logic [14:0] dmapVal = cfg[14:0] == 15'h0000 ? 15'h0001 : cfg[14:0];
   // Enhanced length equals settling, so each result is settled
   wire logic [15:0] enhLen = 16'(longint'(sdf_pkg::ENH_SETTLE_US[enhSel])
      * sdf_pkg::SINC5_SPS / 1_000_000); // [R13] [R14] [R15]
   wire logic [15:0] len1 = enh ? enhLen : ratio; // [R4]
   wire logic [20:0] dec3Len = dmap ?
      21'(sdf_pkg::SINC3_DMAP_MUL) * {6'h00, dmapVal} :
      21'(sdf_pkg::SINC3_DMAP_MUL) * {5'h00, ratio}; // [R7]
   wire logic fastSinc5 = 32'(ratio) * 32'(sdf_pkg::SC_FAST_SPS)
      < 32'(sdf_pkg::SINC5_SPS);
   wire logic scEff = mode_ff[sdf_pkg::SC_BIT] && !multiChan &&
      (isSinc3 || (!enh && fastSinc5)); // [R9]
   // Three bits, since the sinc5 path discards four outputs
   wire logic [2:0] primeNeed = isSinc3 ?
      (scEff ? 3'(sdf_pkg::SINC3_SETTLE_OUT - 1) : 3'h0) :
      3'(sdf_pkg::SINC5_PRIME - 1); // [R3] [R5]

   // ----------------------------------------------------------------
   // Modulator sampling and rate strobes
   // ----------------------------------------------------------------
   // Five-bit sum so scale 15 does not wrap to a zero divider
   wire logic [19:0] divLen = 20'(sdf_pkg::MOD_CYC) *
      {15'h0000, {1'b0, mode_ff[sdf_pkg::SCALE_LSB +: 4]} + 5'h01}; // [R16]
   wire logic modTick = div_ff == divLen - 20'h1;
   wire logic flushing = state_ff == sdf_pkg::ST_FLUSH;
   wire logic dec5 = modTick && cnt5_ff == 5'(sdf_pkg::SINC5_DEC - 1);
   wire logic dec3 = modTick && cnt3_ff == dec3Len - 21'h1;

   // Pin passes two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         div_ff <= 20'h0;
      end else begin
         sync1_ff <= modBit;
         sync2_ff <= sync1_ff;
         div_ff <= modTick ? 20'h0 : div_ff + 20'h1;
      end
   end

   // Decimation counters restart with every flush
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt5_ff <= 5'h0;
         cnt3_ff <= 21'h0;
         d5_ff <= 1'b0;
         d3_ff <= 1'b0;
      end else begin
         d5_ff <= dec5 && !flushing;
         d3_ff <= dec3 && !flushing;
         if (flushing) begin
            cnt5_ff <= 5'h0;
            cnt3_ff <= 21'h0;
         end else if (modTick) begin
            cnt5_ff <= cnt5_ff + 5'h1; // [R4]
            cnt3_ff <= dec3 ? 21'h0 : cnt3_ff + 21'h1;
         end
      end
   end

   assign c5.inValid = modTick && !flushing;
   assign c5.smp = sync2_ff;
   assign c5.decim = dec5 && !flushing;
   assign c5.flush = flushing;
   assign c3.inValid = modTick && !flushing;
   assign c3.smp = sync2_ff;
   assign c3.decim = dec3 && !flushing;
   assign c3.flush = flushing;

   cic_stage #(.ORDER(5), .W(sdf_pkg::W5)) sinc5 (
      .clk(clk),
      .rst_n(rst_n),
      .cic(c5.stage)
   );
   cic_stage #(.ORDER(3), .W(sdf_pkg::W3)) sinc3 (
      .clk(clk),
      .rst_n(rst_n),
      .cic(c3.stage)
   );

   // ----------------------------------------------------------------
   // Conversion control
   // ----------------------------------------------------------------
   wire logic outEvt = isSinc3 ? d3_ff : d5_ff;
   wire logic [sdf_pkg::W1-1:0] s5Ext =
      {{(sdf_pkg::W1-sdf_pkg::W5){c5.out[sdf_pkg::W5-1]}}, c5.out};
   wire logic [sdf_pkg::W1-1:0] accSum = acc_ff + s5Ext;
   wire logic lastAvg = n1_ff == len1 - 16'h1;
   wire logic running = state_ff == sdf_pkg::ST_RUN;
   // Sinc3 without single-cycle emits every output, settled or not
   wire logic emit = running && !chanSwitch &&
      (isSinc3 ? d3_ff : (d5_ff && lastAvg)); // [R10]
   wire logic [31:0] emitVal = isSinc3 ? c3.out[63:32] : accSum[41:10];

   // A settled result under single-cycle mode restarts the filter
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         sdf_pkg::ST_FLUSH: begin
            nxt_state = primeNeed == 3'h0 ? sdf_pkg::ST_RUN :
               sdf_pkg::ST_PRIME;
         end
         // Need may shrink mid-prime (mode or channel count change)
         sdf_pkg::ST_PRIME: begin
            if (primeNeed == 3'h0 ||
               (outEvt && prime_ff >= primeNeed - 3'h1)) begin
               nxt_state = sdf_pkg::ST_RUN;
            end
         end
         sdf_pkg::ST_RUN: begin
            if (emit && scEff) begin
               nxt_state = sdf_pkg::ST_FLUSH; // [R8]
            end
         end
         default: begin
            nxt_state = sdf_pkg::ST_FLUSH;
         end
      endcase
      if (chanSwitch) begin
         nxt_state = sdf_pkg::ST_FLUSH; // [R17]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= sdf_pkg::ST_FLUSH;
         prime_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         prime_ff <= flushing ? 3'h0 :
            (state_ff == sdf_pkg::ST_PRIME && outEvt) ?
            prime_ff + 3'h1 : prime_ff;
      end
   end

   // Sinc1 averaging of sinc5 outputs, also the enhanced post-filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= '0;
         n1_ff <= 16'h0;
      end else if (!running) begin
         acc_ff <= '0;
         n1_ff <= 16'h0;
      end else if (d5_ff) begin
         acc_ff <= lastAvg ? '0 : accSum; // [R4] [R12]
         n1_ff <= lastAvg ? 16'h0 : n1_ff + 16'h1;
      end
   end

   // ----------------------------------------------------------------
   // Results, data-ready and interrupt
   // ----------------------------------------------------------------
   wire logic [2:0] events = {flushing, emit && status_ff[sdf_pkg::EV_READY],
      emit};
   // Only bits reported by the read are cleared; a new event is kept
   wire logic [2:0] clrMask = stRead ? prdata_ff[2:0] : 3'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_ff <= 32'h0000_0000;
         chan_ff <= 4'h0;
         valid_ff <= 1'b0;
         status_ff <= 3'h0;
      end else begin
         valid_ff <= emit;
         status_ff <= (status_ff & ~clrMask) | events;
         if (emit) begin
            result_ff <= emitVal;
            chan_ff <= chanIndex;
         end
      end
   end

   assign result = result_ff;
   assign resultChan = chan_ff;
   assign resultValid = valid_ff;
   assign rdyN = !valid_ff; // [R11]
   assign irq = |(status_ff & mask_ff);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Strobe gap is trusted only once a strobe has followed the last flush
   logic [11:0] gap_ff;
   logic [2:0] outs_ff;
   logic seen5_ff;
   wire logic gapSat = gap_ff == 12'hFFF;
   wire logic outsSat = outs_ff == 3'h7;
   wire logic [2:0] outsInc = (d3_ff && !outsSat) ? outs_ff + 3'h1 : outs_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_ff <= 12'h000;
         outs_ff <= 3'h0;
         seen5_ff <= 1'b0;
      end else begin
         gap_ff <= dec5 ? 12'h000 : (gapSat ? gap_ff : gap_ff + 12'h001);
         outs_ff <= flushing ? 3'h0 : outsInc;
         seen5_ff <= flushing ? 1'b0 : (dec5 || seen5_ff);
      end
   end

   a_rdy_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      emit |=> !rdyN && resultValid ##1 (rdyN || $past(emit)))
      else $error("data-ready pulse does not follow result");
   a_sinc5_rate: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      dec5 && seen5_ff && mode_ff[sdf_pkg::SCALE_LSB +: 4] == 4'h0 &&
      !gapSat |-> gap_ff == 12'hC7F)
      else $error("sinc5 output spacing wrong");
   a_sinc3_settle: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      emit && isSinc3 && scEff |-> outs_ff >= 3'h2)
      else $error("sinc3 settled result not after three outputs");
   a_sinc3_nominal: assert property (@(posedge clk) // [R10]
      disable iff (!rst_n)
      running && isSinc3 && !scEff && d3_ff && !chanSwitch |-> emit)
      else $error("sinc3 output dropped without single-cycle");
   a_direct_len: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      dmap && cfg[14:0] != 15'h0 |-> dec3Len == 21'(cfg[14:0]) * 21'h20)
      else $error("direct map decimation length wrong");
   a_switch_flush: assert property (@(posedge clk) // [R17]
      disable iff (!rst_n)
      chanSwitch |=> flushing ##1 !flushing)
      else $error("channel switch did not flush once");
   a_sc_blocked: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      multiChan || (!isSinc3 && !fastSinc5) |-> !scEff)
      else $error("single-cycle active where it must not be");
   a_sc_restart: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      emit && scEff && !chanSwitch |=> flushing && resultValid)
      else $error("single-cycle result did not restart filter");
   a_enh_path: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
      cfg[sdf_pkg::ENH_EN_BIT] && !isSinc3 |-> enh && len1 == enhLen)
      else $error("enhanced filter not behind sinc5 path");
   a_ready_set: assert property (@(posedge clk) disable iff (!rst_n)
      emit |=> status_ff[sdf_pkg::EV_READY])
      else $error("ready status lost");
   c_sinc3_emit: cover property (@(posedge clk) emit && isSinc3);
   c_enh_emit: cover property (@(posedge clk) emit && enh);
   c_overrun: cover property (@(posedge clk) events[sdf_pkg::EV_OVERRUN]);
   c_sc_emit: cover property (@(posedge clk) emit && scEff);
endmodule
`default_nettype wire
